// File: src/clock_port_pkg.sv
/*
  constants shared by the clock, port and stop-recovery control block:
  register addresses, bit positions, reset values, wake states and the
  post-wake delay.
  assumes a 40 MHz system clock; the address is {bank, register}.
*/
package clock_port_pkg;

  localparam int          CLK_HZ        = 40_000_000;
  localparam int          ADDR_W        = 12;

  // register addresses, upper nibble is the expanded bank
  localparam logic [11:0] ADDR_PORT_OSC = 12'h00F;
  localparam logic [11:0] ADDR_STOP_REC = 12'hF0B;

  // port_oscillator_control fields
  localparam int          PO_COMP_ROUTE = 0;
  localparam int          PO_P1_PUSH    = 1;
  localparam int          PO_P0_PUSH    = 2;
  localparam int          PO_EMI_LSB    = 3;
  localparam int          PO_OSC_STD    = 7;
  localparam logic [7:0]  PORT_OSC_RST  = 8'hFE;

  // stop_recovery_control fields
  localparam int          SR_DIV16      = 0;
  localparam int          SR_NO_DIV2    = 1;
  localparam int          SR_SRC_LSB    = 2;
  localparam int          SR_SRC_MSB    = 4;
  localparam int          SR_DELAY      = 5;
  localparam int          SR_LEVEL      = 6;
  localparam int          SR_WARM       = 7;
  localparam logic [6:0]  STOP_REC_RST  = 7'h20;

  // wake source encodings
  localparam logic [2:0]  SRC_POR_ONLY  = 3'h0;
  localparam logic [2:0]  SRC_P3_LINE0  = 3'h1;
  localparam logic [2:0]  SRC_P3_LINE1  = 3'h2;
  localparam logic [2:0]  SRC_P3_LINE2  = 3'h3;
  localparam logic [2:0]  SRC_P3_LINE3  = 3'h4;
  localparam logic [2:0]  SRC_P2_LINE7  = 3'h5;
  localparam logic [2:0]  SRC_P2_NOR4   = 3'h6;
  localparam logic [2:0]  SRC_P2_NOR8   = 3'h7;

  // clock ratios
  localparam logic [4:0]  DIV_BY_TWO    = 5'h02;
  localparam logic [4:0]  DIV_BY_16     = 5'h10;

  // post-wake reset delay
  localparam int          WAKE_DELAY_MS = 5;
  localparam int          WAKE_DELAY_CYC =
    WAKE_DELAY_MS * (CLK_HZ / 1000);
  localparam int          DLY_W         = 18;

  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_STOPPED = 2'b01,
    ST_DELAY   = 2'b10
  } wake_state_t;

endpackage : clock_port_pkg

// File: src/clock_ratio_divider.sv
/*
  clock ratio divider: gives one tick per core/timer clock period,
  with an optional divide-by-two followed by an optional divide-by-16.
  assumes the caller holds run low while the device is stopped.
*/
`timescale 1ns/1ps
module clock_ratio_divider
  import clock_port_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic run,
  input  wire logic div2En,
  input  wire logic div16En,
  output logic      tick
);

  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic       tick_ff;
  logic [4:0] ratioTop;
  logic       wrap;

  // one counter serves both: with both enabled it tops at 5'h1F, so ratios multiply
  assign ratioTop = (div16En ? (div2En ? 5'h1F : DIV_BY_16 - 5'h01)
                             : (div2En ? DIV_BY_TWO - 5'h01
                                       : 5'h00));
  assign wrap     = (cnt_ff >= ratioTop);
  assign nxt_cnt  = (!run || wrap) ? 5'h00 : cnt_ff + 5'h01;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff  <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= run && wrap;
    end
  end

  assign tick = tick_ff;

endmodule : clock_ratio_divider

// File: src/clock_port_stop_ctrl.sv
/*
  port/oscillator control and stop-recovery control: two registers,
  port drive modes, comparator routing, core/timer clock ratio and
  the STOP wake sequence with its warm-start flag.
  assumes sys_rst is the power-on reset and that the core raises
  stopReq for one cycle when it executes STOP.
*/
// Decided for this implementation: the plain strobed port.
// Function
// - bit 0 set routes comparator outputs onto port3_line4 and port3_line7.
// - bit 1 picks open-drain (0) or push-pull (1) for port 1.
// - bit 2 picks open-drain (0) or push-pull (1) for port 0.
// - bits 3..6 pick low-EMI (0) or standard drive for ports 0..3.
// - bit 7 picks low-noise (0) or standard oscillator drive.
// - stop_recovery_control is write-only except read-only bit 7.
// - bit 7 is set on STOP recovery, cleared only by power-on.
// - stop_recovery_control decodes at bank F, register 0BH.
// - bit 0 engages divide-by-16 on core and timer clocks.
// - bit 1 low halves the external clock, high passes it.
// - bits 2..4 pick the STOP wake source.
// - port3_lines_1_to_3 cannot wake while set as analog inputs.
// - a port 2 pin set as output is sampled from its own drive.
// - bit 6 picks the wake level.
// - bit 5 controls the reset delay after STOP recovery.
// - source codes: none, port3 lines 0..3, port2_line7, two NORs.
// - delay bit high gives 5 ms reset delay, low skips it.
// - level bit high wakes on high, low on low; resets low.
`timescale 1ns/1ps
module clock_port_stop_ctrl
  import clock_port_pkg::*;
#(
  parameter int WAKE_DELAY = WAKE_DELAY_CYC
)
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [7:0]        regRdData,
  // core status
  input  wire logic              stopReq,
  input  wire logic              haltMode,
  // port 0 and port 1 pad drive
  input  wire logic [7:0]        port0Data,
  input  wire logic [7:0]        port0Dir,
  input  wire logic [7:0]        port1Data,
  input  wire logic [7:0]        port1Dir,
  output logic      [7:0]        port0Out,
  output logic      [7:0]        port0OutEn,
  output logic      [7:0]        port1Out,
  output logic      [7:0]        port1OutEn,
  // port 3 lines 4 and 7
  input  wire logic [1:0]        compOut,
  input  wire logic              port3Line4Data,
  input  wire logic              port3Line7Data,
  output logic                   port3Line4Out,
  output logic                   port3Line7Out,
  // wake sources
  input  wire logic [3:0]        port3In,
  input  wire logic [3:1]        port3Analog,
  input  wire logic [7:0]        port2In,
  input  wire logic [7:0]        port2Out,
  input  wire logic [7:0]        port2OutEn,
  // drive strength outputs
  output logic      [3:0]        portStdDrive,
  output logic                   oscStdDrive,
  // clocking and recovery
  output logic                   coreTick,
  output logic                   timerTick,
  output logic                   stopped,
  output logic                   wakeReset,
  output logic                   warmStart
);

  logic [7:0]      portOsc_ff;
  logic [6:0]      stopRec_ff;
  logic            warm_ff;
  logic [7:0]      rdData_ff;
  logic [7:0]      nxt_rdData;
  wake_state_t     state_ff;
  wake_state_t     nxt_state;
  logic [DLY_W-1:0] dly_ff;
  logic [DLY_W-1:0] nxt_dly;
  logic [7:0]      p0Out_ff;
  logic [7:0]      p0En_ff;
  logic [7:0]      p1Out_ff;
  logic [7:0]      p1En_ff;
  logic            p34_ff;
  logic            p37_ff;

  // address decode
  wire selPortOsc  = (regAddr == ADDR_PORT_OSC);
  wire selStopRec  = (regAddr == ADDR_STOP_REC);
  wire wrPortOsc   = regWrite && selPortOsc;
  wire wrStopRec   = regWrite && selStopRec;

  // register fields
  wire       compRoute = portOsc_ff[PO_COMP_ROUTE];
  wire       p1Push    = portOsc_ff[PO_P1_PUSH];
  wire       p0Push    = portOsc_ff[PO_P0_PUSH];
  wire [2:0] wakeSrc   = stopRec_ff[SR_SRC_MSB:SR_SRC_LSB];
  wire       delaySel  = stopRec_ff[SR_DELAY];
  wire       levelSel  = stopRec_ff[SR_LEVEL];
  wire       div16Sel  = stopRec_ff[SR_DIV16];
  wire       noDiv2    = stopRec_ff[SR_NO_DIV2];

  // pad enable for an open-drain or push-pull pin:
  // open-drain only drives while pulling low
  function automatic logic padEnable(
    input logic dirOut,
    input logic data,
    input logic pushPull
  );
    padEnable = dirOut && (pushPull || !data);
  endfunction : padEnable

  // port 2 as seen by the wake logic: an output pin reads back
  // its own drive so a pin cannot wake on a value it is not showing
  wire [7:0] p2Seen;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_p2
      assign p2Seen[g] = port2OutEn[g] ? port2Out[g]
                                       : port2In[g];
    end
  endgenerate

  // wake source selection
  function automatic logic wakeLevel(
    input logic [2:0] src,
    input logic [3:0] p3,
    input logic [7:0] p2
  );
    logic v;
    v = 1'b0;
    if (src == SRC_P3_LINE0) begin
      v = p3[0];
    end else if (src == SRC_P3_LINE1) begin
      v = p3[1];
    end else if (src == SRC_P3_LINE2) begin
      v = p3[2];
    end else if (src == SRC_P3_LINE3) begin
      v = p3[3];
    end else if (src == SRC_P2_LINE7) begin
      v = p2[7];
    end else if (src == SRC_P2_NOR4) begin
      v = ~|p2[3:0];
    end else if (src == SRC_P2_NOR8) begin
      v = ~|p2;
    end
    wakeLevel = v;
  endfunction : wakeLevel

  // an analog line or the power-on-only code never wakes the device;
  // line 0 has no analog mode, so it can always wake
  wire srcBlocked =
    (wakeSrc == SRC_POR_ONLY) ||
    (wakeSrc == SRC_P3_LINE1 && port3Analog[1]) ||
    (wakeSrc == SRC_P3_LINE2 && port3Analog[2]) ||
    (wakeSrc == SRC_P3_LINE3 && port3Analog[3]);

  wire srcLevel = wakeLevel(wakeSrc, port3In, p2Seen);
  // level compare: high when levelSel is 1, low when 0; no filter, so
  // a noisy source wakes the device on its first matching sample
  wire wakeHit  = !srcBlocked &&
                  (srcLevel == levelSel);

  // counting down to zero gives WAKE_DELAY cycles of reset
  wire [DLY_W-1:0] delayLoad =
    delaySel ? DLY_W'(WAKE_DELAY - 1)
             : {DLY_W{1'b0}};

  // wake sequence: stop until the source matches, then hold the
  // core in reset for the delay (one cycle when the delay is off)
  always_comb begin
    nxt_state = state_ff;
    nxt_dly   = dly_ff;
    case (state_ff)
      ST_RUN: begin
        if (stopReq) begin
          nxt_state = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (wakeHit) begin
          nxt_state = ST_DELAY;
          nxt_dly   = delayLoad;
        end
      end
      ST_DELAY: begin
        if (dly_ff == {DLY_W{1'b0}}) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_dly = dly_ff - DLY_W'(1);
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // the flag is set on the edge that leaves STOPPED, together with
  // the start of the post-wake reset
  wire wakeEvent = (state_ff == ST_STOPPED) && wakeHit;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_RUN;
      dly_ff   <= {DLY_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      dly_ff   <= nxt_dly;
    end
  end

  // registers: a stop recovery does not reload them, only power-on
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      portOsc_ff <= PORT_OSC_RST;
    end else if (wrPortOsc) begin
      portOsc_ff <= regWrData;
    end
  end

  // bit 7 is not stored here: the warm flag has no write path
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stopRec_ff <= STOP_REC_RST;
    end else if (wrStopRec) begin
      stopRec_ff <= regWrData[6:0];
    end
  end

  // warm flag has no software clear, so no set/clear race exists
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      warm_ff <= 1'b0;
    end else if (wakeEvent) begin
      warm_ff <= 1'b1;
    end
  end

  // read path: write-only bits of stop recovery read as zero
  wire rdPortOsc = regRead && selPortOsc;
  wire rdStopRec = regRead && selStopRec;
  assign nxt_rdData =
    rdPortOsc ? portOsc_ff :
    rdStopRec ? {warm_ff, 7'h00} :
                              8'h00;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // port 0 and port 1 pad drive
  wire [7:0] p0EnNext;
  wire [7:0] p1EnNext;
  generate
    for (g = 0; g < 8; g++) begin : g_pad
      assign p0EnNext[g] =
        padEnable(port0Dir[g], port0Data[g], p0Push);
      assign p1EnNext[g] =
        padEnable(port1Dir[g], port1Data[g], p1Push);
    end
  endgenerate

  // registered so the pad enables only move on a clock edge, never
  // on a combinational glitch of the data or direction inputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      p0Out_ff <= 8'h00;
      p0En_ff  <= 8'h00;
      p1Out_ff <= 8'h00;
      p1En_ff  <= 8'h00;
    end else begin
      p0Out_ff <= port0Data;
      p0En_ff  <= p0EnNext;
      p1Out_ff <= port1Data;
      p1En_ff  <= p1EnNext;
    end
  end

  // comparator routing on port 3 lines 4 and 7
  wire p34Next = compRoute ? compOut[0] : port3Line4Data;
  wire p37Next = compRoute ? compOut[1] : port3Line7Data;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      p34_ff <= 1'b0;
      p37_ff <= 1'b0;
    end else begin
      p34_ff <= p34Next;
      p37_ff <= p37Next;
    end
  end

  // clock ratio: the divider follows the next state, so the tick
  // registered on the STOP edge is already suppressed and none shows
  // while stopped or in the wake delay; it restarts on the last delay
  // cycle so that the first tick lands in RUN
  wire clkRun  = (nxt_state == ST_RUN);
  wire div2Use = !noDiv2;
  wire rawTick;

  clock_ratio_divider clock_ratio_divider_i (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (clkRun),
    .div2En  (div2Use),
    .div16En (div16Sel),
    .tick    (rawTick)
  );

  // timer clock keeps running in HALT, the core clock does not
  assign coreTick  = rawTick && !haltMode;
  assign timerTick = rawTick;

  assign regRdData    = rdData_ff;
  assign port0Out     = p0Out_ff;
  assign port0OutEn   = p0En_ff;
  assign port1Out     = p1Out_ff;
  assign port1OutEn   = p1En_ff;
  assign port3Line4Out = p34_ff;
  assign port3Line7Out = p37_ff;
  // drive bits pass straight through; oscillator ratio untouched
  assign portStdDrive =
    portOsc_ff[PO_EMI_LSB+3:PO_EMI_LSB];
  assign oscStdDrive  = portOsc_ff[PO_OSC_STD];
  assign stopped      = (state_ff == ST_STOPPED);
  assign wakeReset    = (state_ff == ST_DELAY);
  assign warmStart    = warm_ff;

endmodule : clock_port_stop_ctrl

// File: sim/clock_port_stop_ctrl_props.sv
/*
  checker for clock_port_stop_ctrl: register port, pad drive and wake.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module clock_port_stop_ctrl_checker
  import clock_port_pkg::*;
#(
  parameter int WAKE_DELAY = WAKE_DELAY_CYC
)
(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0]        regWrData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [7:0]        regRdData,
  input wire logic              stopReq,
  input wire logic [7:0]        port0Data,
  input wire logic [7:0]        port0Dir,
  input wire logic [7:0]        port1Data,
  input wire logic [7:0]        port1Dir,
  input wire logic [7:0]        port0OutEn,
  input wire logic [7:0]        port1OutEn,
  input wire logic [1:0]        compOut,
  input wire logic              port3Line4Data,
  input wire logic              port3Line4Out,
  input wire logic [3:0]        portStdDrive,
  input wire logic              oscStdDrive,
  input wire logic              coreTick,
  input wire logic              timerTick,
  input wire logic              stopped,
  input wire logic              wakeReset,
  input wire logic              warmStart
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // shadow copies: the register contents are not visible at the ports
  logic [7:0]  poCopy_ff;
  logic        srDelay_ff;
  logic [31:0] wrLen_ff;
  wire         poWr = regWrite && regAddr == ADDR_PORT_OSC;
  wire         srWr = regWrite && regAddr == ADDR_STOP_REC;
  wire         line4Exp = poCopy_ff[PO_COMP_ROUTE] ? compOut[0]
                                                    : port3Line4Data;
  wire [7:0]   p1EnExp  = poCopy_ff[PO_P1_PUSH] ? port1Dir
                                                 : port1Dir & ~port1Data;
  wire [7:0]   p0EnExp  = poCopy_ff[PO_P0_PUSH] ? port0Dir
                                                 : port0Dir & ~port0Data;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      poCopy_ff  <= PORT_OSC_RST;
      srDelay_ff <= STOP_REC_RST[SR_DELAY];
      wrLen_ff   <= '0;
    end else begin
      if (poWr) poCopy_ff <= regWrData;
      if (srWr) srDelay_ff <= regWrData[SR_DELAY];
      wrLen_ff <= wakeReset ? wrLen_ff + 32'h1 : '0;
    end
  end

  a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  a_sr_read_warm: assert property (
    regRead && regAddr == ADDR_STOP_REC |=> regRdData == {$past(warmStart), 7'h00})
    else $error("stop recovery read wrong");
  a_warm_hold: assert property (warmStart |=> warmStart)
    else $error("warm flag dropped without reset");
  a_stop_entry: assert property (
    stopReq && !stopped && !wakeReset |=> stopped)
    else $error("stop request not taken");
  a_no_tick_stopped: assert property (stopped |-> !timerTick && !coreTick)
    else $error("tick while stopped");
  a_wake_outputs: assert property ($fell(stopped) |-> wakeReset && warmStart)
    else $error("wake without reset or warm flag");
  a_no_tick_reset: assert property (wakeReset |-> !timerTick)
    else $error("tick during post-wake reset");
  a_warm_on_wake: assert property (
    $rose(warmStart) |-> $fell(stopped))
    else $error("warm flag set without a wake");
  a_drive_std: assert property (
    portStdDrive == poCopy_ff[6:3] && oscStdDrive == poCopy_ff[PO_OSC_STD])
    else $error("drive strength outputs disagree with register");
  a_comp_route: assert property (
    !$past(sys_rst) |-> port3Line4Out == $past(line4Exp))
    else $error("port3 line4 routing wrong");
  a_p1_drive: assert property (!$past(sys_rst) |-> port1OutEn == $past(p1EnExp))
    else $error("port1 output enable wrong");
  a_p0_drive: assert property (!$past(sys_rst) |-> port0OutEn == $past(p0EnExp))
    else $error("port0 output enable wrong");
  a_delay_len: assert property (
    $fell(wakeReset) |-> wrLen_ff == (srDelay_ff ? WAKE_DELAY : 1))
    else $error("post-wake reset length wrong");

  c_slow_wake: cover property ($fell(wakeReset) && srDelay_ff);
  c_fast_wake: cover property ($fell(wakeReset) && !srDelay_ff);
  c_warm_read: cover property (regRead && regAddr == ADDR_STOP_REC && warmStart);
endmodule : clock_port_stop_ctrl_checker

bind clock_port_stop_ctrl clock_port_stop_ctrl_checker #(.WAKE_DELAY(WAKE_DELAY))
  chk_i (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .stopReq(stopReq), .port0Data(port0Data),
  .port0Dir(port0Dir), .port1Data(port1Data), .port1Dir(port1Dir),
  .port0OutEn(port0OutEn), .port1OutEn(port1OutEn), .compOut(compOut),
  .port3Line4Data(port3Line4Data), .port3Line4Out(port3Line4Out),
  .portStdDrive(portStdDrive), .oscStdDrive(oscStdDrive),
  .coreTick(coreTick), .timerTick(timerTick), .stopped(stopped),
  .wakeReset(wakeReset), .warmStart(warmStart));

// File: sim/clock_port_stop_ctrl_tb_top.sv
/*
  self-checking bench for clock_port_stop_ctrl: registers, pads, ratios,
  wake sources. assumes a short post-wake delay parameter of 20 cycles.
*/
`timescale 1ns/1ps
module clock_port_stop_ctrl_tb_top;
  import clock_port_pkg::*;
  localparam int DLY = 20;
  logic              clock, sys_rst, regWrite, regRead, stopReq, haltMode;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0]        regWrData, regRdData, port0Data, port0Dir, port1Data;
  logic [7:0]        port1Dir, port0Out, port0OutEn, port1Out, port1OutEn;
  logic [7:0]        port2In, port2Out, port2OutEn;
  logic [1:0]        compOut;
  logic              port3Line4Data, port3Line7Data, port3Line4Out;
  logic              port3Line7Out, oscStdDrive, coreTick, timerTick;
  logic              stopped, wakeReset, warmStart;
  logic [3:0]        port3In, portStdDrive;
  logic [3:1]        port3Analog;
  int                fails, n_compared, n, m;

  clock_port_stop_ctrl #(.WAKE_DELAY(DLY)) clock_port_stop_ctrl_i (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .stopReq(stopReq), .haltMode(haltMode),
    .port0Data(port0Data), .port0Dir(port0Dir), .port1Data(port1Data),
    .port1Dir(port1Dir), .port0Out(port0Out), .port0OutEn(port0OutEn),
    .port1Out(port1Out), .port1OutEn(port1OutEn), .compOut(compOut),
    .port3Line4Data(port3Line4Data), .port3Line7Data(port3Line7Data),
    .port3Line4Out(port3Line4Out), .port3Line7Out(port3Line7Out),
    .port3In(port3In), .port3Analog(port3Analog), .port2In(port2In),
    .port2Out(port2Out), .port2OutEn(port2OutEn),
    .portStdDrive(portStdDrive), .oscStdDrive(oscStdDrive),
    .coreTick(coreTick), .timerTick(timerTick), .stopped(stopped),
    .wakeReset(wakeReset), .warmStart(warmStart));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a; regWrData <= d; regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the read strobe
  task rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a; regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rdc

  // first two periods after a ratio change are discarded
  task per(input int e);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clock);
        #1 n++;
      end while (timerTick !== 1'b1 && n < 100);
    end
    chk(n, e);
  endtask : per

  task pins(input logic [2:0] s, input logic on);
    case (s)
      3'h5: begin
        port2Out <= on ? 8'h7F : 8'hFF; port2OutEn <= on ? 8'h80 : 8'h00;
      end
      3'h6: port2In <= on ? 8'hF0 : 8'hFF;
      3'h7: port2In <= on ? 8'h00 : 8'hFF;
      default: port3In <= on ? ~(4'h1 << (s - 3'h1)) : 4'hF;
    endcase
  endtask : pins

  task wake(input logic [2:0] s, input logic lvl, input logic dly);
    wr(ADDR_STOP_REC, {1'b0, lvl, dly, s, 2'b00});
    @(posedge clock); stopReq <= 1'b1;
    @(posedge clock); stopReq <= 1'b0;
    #1 chk(stopped, 1'b1);
    @(posedge clock);
    port3Analog <= (s inside {[3'h2:3'h4]}) ? 3'b111 : 3'b000;
    pins(s, 1'b1);
    if (s inside {[3'h2:3'h4]}) begin
      repeat (4) @(posedge clock);
      chk(stopped, 1'b1);
      port3Analog <= 3'b000;
    end
    n = 0;
    while (wakeReset !== 1'b1 && n < 10) begin @(posedge clock); n++; end
    n = 0;
    while (wakeReset === 1'b1 && n < 100) begin @(posedge clock); n++; end
    chk(n, dly ? DLY : 1);
    chk({stopped, warmStart}, 2'b01);
    pins(s, 1'b0);
  endtask : wake

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    wrap_up();
  end

  initial begin
    {sys_rst, regWrite, regRead, stopReq, haltMode} = 5'b10000;
    {regAddr, regWrData, port0Data, port0Dir, port1Data, port1Dir} = '0;
    {compOut, port3Line4Data, port3Line7Data} = '0;
    {port2In, port2Out, port2OutEn} = {8'hFF, 8'hFF, 8'h00};
    {port3In, port3Analog} = {4'hF, 3'b000};
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    chk({portStdDrive, oscStdDrive}, 5'h1F);
    rdc(ADDR_PORT_OSC, 8'hFE);
    rdc(ADDR_STOP_REC, 8'h00);
    rdc(12'h00B, 8'h00);
    $display("test reset values done");
    @(posedge clock);
    {compOut, port3Line4Data, port3Line7Data} <= 4'b1010;
    {port1Dir, port1Data, port0Dir, port0Data} <= 32'hFF0F_0F05;
    wr(ADDR_PORT_OSC, 8'h01);
    repeat (2) @(posedge clock);
    chk({portStdDrive, oscStdDrive}, 5'h00);
    chk({port3Line4Out, port3Line7Out}, 2'b01);
    chk({port1OutEn, port0OutEn, port1Out, port0Out}, 32'hF00A0F05);
    wr(12'h123, 8'hFE);
    rdc(ADDR_PORT_OSC, 8'h01);
    wr(ADDR_PORT_OSC, 8'hFE);
    repeat (2) @(posedge clock);
    chk({port3Line4Out, port3Line7Out}, 2'b10);
    chk({port1OutEn, port0OutEn}, 16'hFF0F);
    $display("test port control done");
    wr(ADDR_STOP_REC, 8'h20); per(2);
    wr(ADDR_STOP_REC, 8'h22); per(1);
    wr(ADDR_STOP_REC, 8'h21); per(32);
    wr(ADDR_STOP_REC, 8'h23); per(16);
    haltMode <= 1'b1;
    n = 0;
    m = 0;
    repeat (32) begin @(posedge clock); n += coreTick; m += timerTick; end
    chk(n, 0);
    chk(m, 2);
    haltMode <= 1'b0;
    n = 0;
    repeat (32) begin @(posedge clock); n += coreTick; end
    chk(n, 2);
    $display("test clock ratios done");
    // low level for the pins, high level for the two NOR sources
    for (int i = 1; i < 8; i++) wake(i[2:0], i > 5, i[0]);
    $display("test wake sources done");
    wr(ADDR_PORT_OSC, 8'h01);
    wr(ADDR_STOP_REC, 8'h00);
    @(posedge clock); stopReq <= 1'b1;
    @(posedge clock); stopReq <= 1'b0; port3In <= 4'h0;
    repeat (8) @(posedge clock);
    chk(stopped, 1'b1);
    sys_rst <= 1'b1; port3In <= 4'hF;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk(warmStart, 1'b0);
    rdc(ADDR_STOP_REC, 8'h00);
    rdc(ADDR_PORT_OSC, 8'hFE);
    wr(ADDR_STOP_REC, 8'h80);
    rdc(ADDR_STOP_REC, 8'h00);
    $display("test power-on only done");
    wrap_up();
  end
endmodule : clock_port_stop_ctrl_tb_top
